/* File: rtl/vimc_pkg.sv */
package vimc_pkg;

  // ==========================================================================
  // apb register map (byte addresses)
  // ==========================================================================
  localparam logic [7:0]  VIMC_REG_FEATURE_DIS = 8'h00;  // feature_disable_reg mirror
  localparam logic [7:0]  VIMC_REG_STATUS      = 8'h04;  // synchronised pins and mode
  localparam logic [7:0]  VIMC_REG_BLANK       = 8'h08;  // blanking levels

  // ==========================================================================
  // feature_disable_reg field positions
  // ==========================================================================
  localparam int          VIMC_F_EDH      = 0;  // edh packets, sd only
  localparam int          VIMC_F_PKT352   = 1;  // 352m payload packets
  localparam int          VIMC_F_ANC      = 2;  // anc checksum
  localparam int          VIMC_F_CRC      = 3;  // line crc, hd only
  localparam int          VIMC_F_LNUM     = 4;  // line numbering, hd only
  localparam int          VIMC_F_TRS      = 5;  // trs generation
  localparam int          VIMC_F_REMAP    = 6;  // illegal code remap
  localparam int          VIMC_F_HCFG     = 7;  // line_flag_timing_sel
  localparam int          VIMC_NFEAT      = 7;
  localparam logic [7:0]  VIMC_FDIS_RST   = 8'h00;

  // ==========================================================================
  // blanking levels after reset
  // ==========================================================================
  localparam logic [9:0]  VIMC_LUMA_BLANK_RST   = 10'h040;
  localparam logic [9:0]  VIMC_CHROMA_BLANK_RST = 10'h200;

  // ==========================================================================
  // host serial port framing
  // ==========================================================================
  localparam int          VIMC_HWORD      = 16;         // bits per command or data word
  localparam int          VIMC_HCMD_RD    = 15;         // command bit: 1 read, 0 write
  localparam logic [11:0] VIMC_HADDR_FDIS = 12'h000;    // feature_disable_reg
  localparam logic [11:0] VIMC_HADDR_STAT = 12'h001;    // status word

  // ==========================================================================
  // pin vector layout at the synchroniser
  // ==========================================================================
  localparam int          VIMC_P_DIN      = 0;   // 20 bits of parallel word
  localparam int          VIMC_P_RATE     = 20;
  localparam int          VIMC_P_WIDTH    = 21;
  localparam int          VIMC_P_PROC     = 22;
  localparam int          VIMC_P_CODE     = 23;
  localparam int          VIMC_P_ASI      = 24;
  localparam int          VIMC_P_TSRC     = 25;
  localparam int          VIMC_P_LDRV     = 26;
  localparam int          VIMC_P_TEST     = 27;
  localparam int          VIMC_P_RSTN     = 28;
  localparam int          VIMC_P_BLANKN   = 29;
  localparam int          VIMC_P_ROW      = 30;
  localparam int          VIMC_P_FRAME    = 31;
  localparam int          VIMC_P_FIELD    = 32;
  localparam int          VIMC_P_SEL      = 33;
  localparam int          VIMC_P_SCLK     = 34;
  localparam int          VIMC_P_SIN      = 35;
  localparam int          VIMC_P_TDO      = 36;
  localparam int          VIMC_NPIN       = 37;

  typedef enum logic [1:0] {
    VIMC_HP_IDLE,
    VIMC_HP_CMD,
    VIMC_HP_DATA
  } vimc_hp_e;

endpackage : vimc_pkg

/* File: rtl/vimc_top.sv */
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/1ps

// How it works
// - lower parallel bits form a bus, bit 9 most significant, bit 0 least.
// - in 20-bit modes lower bits carry chroma in smpte mode, data in data-through.
// - in both 10-bit modes the lower bits stay high impedance in every mode.
// - sd 20-bit with async stream mode holds the lower bits in high impedance.
// - processing_enable high enables edh, 352m, anc, crc, line number, trs, remap.
// - processing_enable low disables every feature whatever feature_disable_reg says.
// - coding enabled and async mode low gives smpte mode, features allowed.
// - coding disabled means no scrambling, no encoding and no features.
// - host mode shared reset low restores defaults and floats all pins.
// - test mode shared reset low restores defaults and holds jtag in reset.
// - blank low outside async stream mode replaces luma, chroma and ancillary data by blanking levels.
// - select pin is active-low chip select in host mode, tms in test mode.
// - host words are shifted in with the host-driven serial clock.
// - host writes through serial input, device answers on serial output.
// - external timing with processing on sets trs h bit while row flag high.
// - frame flag feeds trs v bit, ignored when embedded timing is chosen.
// - even_odd_in high in field 2 feeds the trs f bit.
// - line_driver_enable low floats both serial line outputs, high drives them.
// - test select high gives shared pins to jtag, low to host serial port.
// - external timing select locks flywheel to external row, frame, field flags.
// - bus_width_select high means 20-bit demuxed input, low 10-bit muxed.
// - rate_select high means 270mb/s only, low means high-definition rates.
// - async stream mode needs async pin high, sd rate and coding disabled.
module vimc_top
  import vimc_pkg::*;
(
  input  wire logic        sys_clk,              // 40 mhz system clock
  input  wire logic        sys_rst,              // synchronous reset, active high
  // apb slave
  input  wire logic        psel,                 // apb select
  input  wire logic        penable,              // apb access phase
  input  wire logic        pwrite,               // apb write
  input  wire logic [7:0]  paddr,                // apb byte address
  input  wire logic [31:0] pwdata,               // apb write data
  output logic      [31:0] prdata,               // apb read data
  output logic             pready,               // apb ready
  output logic             pslverr,              // apb error on unmapped address
  // parallel video pins
  input  wire logic [9:0]  din_hi,               // upper parallel word, luma or muxed
  input  wire logic [9:0]  din_lo,               // lower parallel word, chroma or data
  input  wire logic        rate_select,          // 1 sd rate, 0 hd rates
  input  wire logic        bus_width_select,     // 1 20-bit, 0 10-bit
  input  wire logic        processing_enable,    // global feature enable
  input  wire logic        video_coding_enable,  // 1 smpte coding, 0 bypass
  input  wire logic        async_stream_mode,    // async stream request
  input  wire logic        timing_source_select, // 0 external flags, 1 embedded trs
  input  wire logic        line_driver_enable,   // serial line output stage enable
  input  wire logic        test_or_host_select,  // 1 jtag, 0 host serial port
  input  wire logic        reset_n_shared,       // shared reset, active low
  input  wire logic        blank_n_in,           // 0 blank the data
  input  wire logic        row_blanking_in,      // horizontal blanking flag
  input  wire logic        frame_blanking_in,    // vertical blanking flag
  input  wire logic        even_odd_in,          // field 2 flag
  // shared host serial / jtag pins
  input  wire logic        select_or_mode_pin,   // chip select low or tms
  input  wire logic        serial_clock_pin,     // host serial clock or tck
  input  wire logic        serial_in_pin,        // host data in or tdi
  output logic             serial_out_pin_o,     // host data out or tdo
  output logic             serial_out_pin_oe,    // high while driving serial_out_pin
  input  wire logic        jtag_tdo_in,          // tdo from boundary scan chain
  output logic             jtag_tms,             // tms to boundary scan chain
  output logic             jtag_tck,             // tck to boundary scan chain
  output logic             jtag_tdi,             // tdi to boundary scan chain
  output logic             jtag_trst_n,          // jtag sequence reset, active low
  // processed stream towards the serializer
  output logic [9:0]       word_hi,              // upper word after blanking
  output logic [9:0]       word_lo,              // lower word after blanking
  output logic             lo_bus_hiz,           // lower input bus held in high impedance
  output logic             din_pins_hiz,         // all input pins floated
  output logic             smpte_mode,           // smpte coding mode active
  output logic             asi_mode,             // async stream mode active
  output logic             scramble_enable,      // scrambling and nrzi coding on
  output logic [6:0]       feature_en,           // per feature enable vector
  output logic             trs_h,                // outgoing trs h bit
  output logic             trs_v,                // outgoing trs v bit
  output logic             trs_f,                // outgoing trs f bit
  output logic             flywheel_ext_lock,    // flywheel locked to external flags
  output logic             line_flag_timing_sel, // row flag timing mode
  output logic             serial_line_oe        // serial line outputs driven
);

  // ==========================================================================
  // state
  // ==========================================================================
  typedef struct packed {
    logic [VIMC_NPIN-1:0] sync1;
    logic [VIMC_NPIN-1:0] sync2;
    logic                 sclk_d;
    logic [7:0]           fdis;
    logic [9:0]           luma_lvl;
    logic [9:0]           chroma_lvl;
    logic                 mux_phase;
    vimc_hp_e             hp_state;
    logic [4:0]           hp_cnt;
    logic [15:0]          hp_shift;
    logic                 hp_read;
    logic [11:0]          hp_addr;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic                 sout;
    logic                 sout_oe;
    logic                 tms;
    logic                 tck;
    logic                 tdi;
    logic                 trst_n;
    logic [9:0]           word_hi;
    logic [9:0]           word_lo;
    logic                 lo_hiz;
    logic                 all_hiz;
    logic                 smpte;
    logic                 asi;
    logic                 scramble;
    logic [6:0]           feat;
    logic                 trs_h;
    logic                 trs_v;
    logic                 trs_f;
    logic                 ext_lock;
    logic                 hcfg;
    logic                 line_oe;
  } vimc_state_s;

  vimc_state_s st;
  vimc_state_s next_st;

  logic [VIMC_NPIN-1:0] pin_raw;

  // every pin enters in one vector so the synchroniser is uniform
  assign pin_raw = {jtag_tdo_in, serial_in_pin, serial_clock_pin, select_or_mode_pin,
                    even_odd_in, frame_blanking_in, row_blanking_in, blank_n_in,
                    reset_n_shared, test_or_host_select, line_driver_enable,
                    timing_source_select, async_stream_mode, video_coding_enable,
                    processing_enable, bus_width_select, rate_select, din_lo, din_hi};

  // status word shared by apb and host serial reads
  function automatic logic [15:0] vimc_status(input vimc_state_s s);
    vimc_status = {s.asi, s.smpte, 1'b0, s.sync2[VIMC_P_FIELD:VIMC_P_RATE]};
  endfunction

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb begin
    logic [9:0]  hi;
    logic [9:0]  lo;
    logic        rate_sd;
    logic        wide;
    logic        proc_on;
    logic        code_on;
    logic        asi_pin;
    logic        ext_tim;
    logic        test_m;
    logic        rst_sh;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        cs_act;
    logic        smpte_n;
    logic        asi_n;
    logic        apb_acc;
    logic [15:0] hp_word;
    hi        = '0;
    lo        = '0;
    next_st   = st;
    // two flops on every pin before use
    next_st.sync1  = pin_raw;
    next_st.sync2  = st.sync1;
    next_st.sclk_d = st.sync2[VIMC_P_SCLK];
    hi        = st.sync2[VIMC_P_DIN +: 10];
    lo        = st.sync2[VIMC_P_DIN+10 +: 10];
    rate_sd   = st.sync2[VIMC_P_RATE];
    wide      = st.sync2[VIMC_P_WIDTH];
    proc_on   = st.sync2[VIMC_P_PROC];
    code_on   = st.sync2[VIMC_P_CODE];
    asi_pin   = st.sync2[VIMC_P_ASI];
    ext_tim   = ~st.sync2[VIMC_P_TSRC];
    test_m    = st.sync2[VIMC_P_TEST];
    rst_sh    = ~st.sync2[VIMC_P_RSTN];
    sclk_rise = st.sync2[VIMC_P_SCLK] & ~st.sclk_d;
    sclk_fall = ~st.sync2[VIMC_P_SCLK] & st.sclk_d;
    cs_act    = ~test_m & ~st.sync2[VIMC_P_SEL];
    apb_acc   = psel & penable & ~st.pready;
    hp_word   = '0;

    // mode decode
    smpte_n = code_on & ~asi_pin;
    asi_n   = asi_pin & rate_sd & ~code_on;
    next_st.smpte    = smpte_n;
    next_st.asi      = asi_n;
    next_st.scramble = code_on;
    next_st.ext_lock = ext_tim;
    next_st.hcfg     = st.fdis[VIMC_F_HCFG];

    // features need smpte mode and the global enable
    for (int i = 0; i < VIMC_NFEAT; i++) begin
      next_st.feat[i] = proc_on & smpte_n & ~st.fdis[i];
    end
    next_st.feat[VIMC_F_EDH]  = next_st.feat[VIMC_F_EDH] & rate_sd;
    next_st.feat[VIMC_F_CRC]  = next_st.feat[VIMC_F_CRC] & ~rate_sd;
    next_st.feat[VIMC_F_LNUM] = next_st.feat[VIMC_F_LNUM] & ~rate_sd;

    // lower bus usage per rate, width and mode
    next_st.lo_hiz = ~wide | (rate_sd & asi_n);

    // blanking; in 10-bit mode the word alternates chroma then luma
    next_st.mux_phase = wide ? 1'b0 : ~st.mux_phase;
    if (!st.sync2[VIMC_P_BLANKN] && !asi_n) begin
      if (wide) begin
        hi = st.luma_lvl;
        lo = st.chroma_lvl;
      end else begin
        hi = st.mux_phase ? st.luma_lvl : st.chroma_lvl;
      end
    end
    next_st.word_hi = hi;
    next_st.word_lo = next_st.lo_hiz ? 10'h000 : lo;

    // external timing flags into the trs bits
    if (ext_tim && proc_on && next_st.feat[VIMC_F_TRS]) begin
      next_st.trs_h = st.sync2[VIMC_P_ROW];
      next_st.trs_v = st.sync2[VIMC_P_FRAME];
      next_st.trs_f = st.sync2[VIMC_P_FIELD];
    end else begin
      next_st.trs_h = 1'b0;
      next_st.trs_v = 1'b0;
      next_st.trs_f = 1'b0;
    end

    // output stage
    next_st.line_oe = st.sync2[VIMC_P_LDRV];
    next_st.all_hiz = 1'b0;

    // shared pins: jtag passes through, host mode runs the serial port
    next_st.tms    = test_m & st.sync2[VIMC_P_SEL];
    next_st.tck    = test_m & st.sync2[VIMC_P_SCLK];
    next_st.tdi    = test_m & st.sync2[VIMC_P_SIN];
    next_st.trst_n = ~(test_m & rst_sh);
    if (test_m) begin
      next_st.sout     = st.sync2[VIMC_P_TDO];
      next_st.sout_oe  = 1'b1;
      next_st.hp_state = VIMC_HP_IDLE;
    end else if (!cs_act) begin
      next_st.hp_state = VIMC_HP_IDLE;
      next_st.sout_oe  = 1'b0;
      next_st.hp_cnt   = '0;
    end else begin
      case (st.hp_state)
        VIMC_HP_IDLE: begin
          next_st.hp_state = VIMC_HP_CMD;
          next_st.hp_cnt   = '0;
        end
        VIMC_HP_CMD: begin
          if (sclk_rise) begin
            next_st.hp_shift = {st.hp_shift[14:0], st.sync2[VIMC_P_SIN]};
            next_st.hp_cnt   = st.hp_cnt + 5'd1;
            if (st.hp_cnt == 5'(VIMC_HWORD - 1)) begin
              hp_word          = {st.hp_shift[14:0], st.sync2[VIMC_P_SIN]};
              next_st.hp_read  = hp_word[VIMC_HCMD_RD];
              next_st.hp_addr  = hp_word[11:0];
              next_st.hp_cnt   = '0;
              next_st.hp_state = VIMC_HP_DATA;
              // preload the read word so its first bit leads the next rise
              if (hp_word[11:0] == VIMC_HADDR_FDIS) begin
                next_st.hp_shift = {8'h00, st.fdis};
              end else if (hp_word[11:0] == VIMC_HADDR_STAT) begin
                next_st.hp_shift = vimc_status(st);
              end else begin
                next_st.hp_shift = '0;
              end
            end
          end
        end
        VIMC_HP_DATA: begin
          next_st.sout_oe = st.hp_read;
          if (sclk_fall && st.hp_read) begin
            next_st.sout = st.hp_shift[15];
          end
          if (sclk_rise) begin
            next_st.hp_shift = {st.hp_shift[14:0], st.sync2[VIMC_P_SIN]};
            next_st.hp_cnt   = st.hp_cnt + 5'd1;
            if (st.hp_cnt == 5'(VIMC_HWORD - 1)) begin
              next_st.hp_cnt   = '0;
              next_st.hp_state = VIMC_HP_CMD;
              if (!st.hp_read && st.hp_addr == VIMC_HADDR_FDIS) begin
                next_st.fdis = next_st.hp_shift[7:0];
              end
            end
          end
        end
        default: next_st.hp_state = VIMC_HP_IDLE;
      endcase
    end

    // apb slave: answer in the second access cycle, error on unmapped
    next_st.pready  = apb_acc;
    next_st.pslverr = 1'b0;
    next_st.prdata  = '0;
    if (apb_acc) begin
      case (paddr)
        VIMC_REG_FEATURE_DIS: begin
          if (pwrite) begin
            next_st.fdis = pwdata[7:0];
          end
          next_st.prdata = {24'h000000, st.fdis};
        end
        VIMC_REG_STATUS: begin
          next_st.prdata = {16'h0000, vimc_status(st)};
        end
        VIMC_REG_BLANK: begin
          if (pwrite) begin
            next_st.luma_lvl   = pwdata[9:0];
            next_st.chroma_lvl = pwdata[25:16];
          end
          next_st.prdata = {6'h00, st.chroma_lvl, 6'h00, st.luma_lvl};
        end
        default: next_st.pslverr = 1'b1;
      endcase
    end

    // shared reset: defaults everywhere, floating pins in host mode
    if (rst_sh) begin
      next_st.fdis       = VIMC_FDIS_RST;
      next_st.luma_lvl   = VIMC_LUMA_BLANK_RST;
      next_st.chroma_lvl = VIMC_CHROMA_BLANK_RST;
      next_st.hp_state   = VIMC_HP_IDLE;
      next_st.feat       = '0;
      next_st.trs_h      = 1'b0;
      next_st.trs_v      = 1'b0;
      next_st.trs_f      = 1'b0;
      next_st.word_hi    = '0;
      next_st.word_lo    = '0;
      if (!test_m) begin
        next_st.all_hiz = 1'b1;
        next_st.lo_hiz  = 1'b1;
        next_st.line_oe = 1'b0;
        next_st.sout_oe = 1'b0;
      end
    end
  end

  // ==========================================================================
  // registers
  // ==========================================================================
  // one clocked process; reset gives constants only
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st            <= '0;
      st.fdis       <= VIMC_FDIS_RST;
      st.luma_lvl   <= VIMC_LUMA_BLANK_RST;
      st.chroma_lvl <= VIMC_CHROMA_BLANK_RST;
      st.hp_state   <= VIMC_HP_IDLE;
      st.trst_n     <= 1'b0;
      st.lo_hiz     <= 1'b1;
      st.all_hiz    <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // outputs straight from state
  // ==========================================================================
  assign prdata               = st.prdata;
  assign pready               = st.pready;
  assign pslverr              = st.pslverr;
  assign serial_out_pin_o     = st.sout;
  assign serial_out_pin_oe    = st.sout_oe;
  assign jtag_tms             = st.tms;
  assign jtag_tck             = st.tck;
  assign jtag_tdi             = st.tdi;
  assign jtag_trst_n          = st.trst_n;
  assign word_hi              = st.word_hi;
  assign word_lo              = st.word_lo;
  assign lo_bus_hiz           = st.lo_hiz;
  assign din_pins_hiz         = st.all_hiz;
  assign smpte_mode           = st.smpte;
  assign asi_mode             = st.asi;
  assign scramble_enable      = st.scramble;
  assign feature_en           = st.feat;
  assign trs_h                = st.trs_h;
  assign trs_v                = st.trs_v;
  assign trs_f                = st.trs_f;
  assign flywheel_ext_lock    = st.ext_lock;
  assign line_flag_timing_sel = st.hcfg;
  assign serial_line_oe       = st.line_oe;

endmodule // vimc_top

/* File: dv/vimc_chk_asserts.sv */
`timescale 1ns/1ps
// =====
// checker on the top ports, bound below
module vimc_chk (
  input wire logic       sys_clk, sys_rst, psel, penable, pready,
  input wire logic       line_driver_enable, test_or_host_select, jtag_tck,
  input wire logic [6:0] feature_en,
  input wire logic       smpte_mode, asi_mode, scramble_enable, lo_bus_hiz,
  input wire logic       din_pins_hiz, serial_line_oe, serial_out_pin_oe,
  input wire logic       trs_h, trs_v, trs_f, flywheel_ext_lock
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // a taken access; one wait state so a held request is never served twice
  sequence apb_take; psel && penable && !pready; endsequence
  chk_apb_ready_pulse: assert property (apb_take |=> pready ##1 !pready)
    else $error("apb ready not a single pulse");
  chk_features_off: assert property (!smpte_mode |-> feature_en == 7'h00)
    else $error("features on outside smpte mode");
  chk_asi_lo_hiz: assert property (asi_mode |-> lo_bus_hiz)
    else $error("lower bus driven in async mode");
  chk_asi_no_coding: assert property (asi_mode |-> !smpte_mode && !scramble_enable)
    else $error("coding active in async mode");
  chk_pins_float: assert property (din_pins_hiz |-> !serial_line_oe && !serial_out_pin_oe)
    else $error("outputs driven while pins float");
  chk_trs_gate: assert property ((trs_h || trs_v || trs_f) |-> feature_en[5] && flywheel_ext_lock)
    else $error("trs bit without trs feature or external timing");
  chk_tck_in_test: assert property (jtag_tck |-> $past(test_or_host_select, 3))
    else $error("test clock passed in host mode");
  chk_line_drv_pin: assert property (serial_line_oe |-> $past(line_driver_enable, 3))
    else $error("line outputs driven while disabled");
endmodule // vimc_chk
bind vimc_top vimc_chk u_chk (.*);

/* File: dv/vimc_src.sv */
`timescale 1ns/1ps
// =====
// video source: words follow a counter so the bench can predict them
module vimc_src (
  input  wire logic       sys_clk,           // word clock
  input  wire logic       sys_rst,           // sync reset
  output logic      [9:0] din_hi,            // upper word
  output logic      [9:0] din_lo,            // lower word
  output logic            row_blanking_in,   // line blanking
  output logic            frame_blanking_in, // vertical blanking
  output logic            even_odd_in        // second field
);
  logic [10:0] cnt;
  always_ff @(posedge sys_clk) cnt <= sys_rst ? 11'h000 : cnt + 11'h001;
  assign din_hi = cnt[9:0];
  assign din_lo = cnt[9:0] ^ 10'h2aa;
  assign row_blanking_in = cnt[3:0] < 4'h4;
  assign frame_blanking_in = cnt[9:6] == 4'h0;
  assign even_odd_in = cnt[10];
endmodule // vimc_src

/* File: dv/test_video_input_mode_control.sv */
`timescale 1ns/1ps
// =====
// bench: apb access, random mode sweep, datapath and shared reset
module test_video_input_mode_control;
  import vimc_pkg::*;
  logic sys_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic reset_n_shared = 1, blank_n_in = 1, select_or_mode_pin = 1, serial_in_pin = 0;
  logic jtag_tdo_in = 0, serial_out_pin_o, serial_out_pin_oe, jtag_tms, jtag_tck, jtag_tdi;
  logic jtag_trst_n, lo_bus_hiz, din_pins_hiz, smpte_mode, asi_mode, scramble_enable, trs_h;
  logic trs_v, trs_f, flywheel_ext_lock, line_flag_timing_sel, serial_line_oe, sm, as, g;
  logic rate_select, bus_width_select, processing_enable, video_coding_enable;
  logic async_stream_mode, timing_source_select, line_driver_enable, test_or_host_select;
  logic serial_clock_pin, row_blanking_in, frame_blanking_in, even_odd_in;
  logic [6:0] feature_en;
  logic [7:0] paddr = 0, fd;
  logic [8:0] m = 0;
  logic [10:0] d;
  logic [15:0] hr;
  logic [9:0] din_hi, din_lo, word_hi, word_lo;
  logic [31:0] pwdata = 0, prdata, rd;
  int fail_count = 0, checks = 0, cyc = 0;
  assign {serial_clock_pin, test_or_host_select, line_driver_enable, timing_source_select,
          async_stream_mode, video_coding_enable, processing_enable, bus_width_select,
          rate_select} = m;
  vimc_top uut (.*);
  vimc_src u_src (.*);
  initial forever #12.5 sys_clk = ~sys_clk;
  task chk(input string n, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  // request held until the edge that samples pready high, data taken and released there
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge sys_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge sys_clk);
    penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1 && ++t < 20);
    if (pready !== 1'b1) fail_count++;
    {rd, er} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask
  // one host word, msb first; each sclk phase is long enough for the pin synchroniser
  task host_word(input logic [15:0] w);
    for (int b = 15; b >= 0; b--) begin
      @(posedge sys_clk);
      {m[8], serial_in_pin} <= {1'b0, w[b]};
      repeat (4) @(posedge sys_clk);
      hr = {hr[14:0], serial_out_pin_o};
      m[8] <= 1'b1;
      repeat (3) @(posedge sys_clk);
    end
  endtask
  // pins need two sync flops and an output flop, so wait past that
  task settle(input logic [8:0] v);
    @(posedge sys_clk);
    m <= v;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task end_of_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge sys_clk) if (++cyc == 20000) begin
    fail_count++;
    end_of_test();
  end
  initial begin
    void'($urandom(36102));
    repeat (3) @(posedge sys_clk);
    sys_rst <= 0;
    apb(0, VIMC_REG_BLANK, 0);
    chk("blank levels", {6'h00, VIMC_CHROMA_BLANK_RST, 6'h00, VIMC_LUMA_BLANK_RST}, rd);
    fd = 8'($urandom) & 8'hdf;
    apb(1, VIMC_REG_FEATURE_DIS, {24'h0, fd});
    apb(0, VIMC_REG_FEATURE_DIS, 0);
    chk("feature disable", {24'h0, fd}, rd);
    apb(0, 8'h0c, 0);
    chk("unmapped", 32'h1, {rd[30:0], er});
    for (int i = 0; i < 200; i++) begin
      settle(i == 0 ? 9'h053 : i == 1 ? 9'h00c : 9'($urandom));
      sm = m[3] & !m[4];
      as = m[4] & m[0] & !m[3];
      d = 11'(u_src.cnt - 11'd3);
      g = m[2] & sm & !m[5];
      chk("smpte mode", sm, smpte_mode);
      chk("async mode", as, asi_mode);
      chk("lower bus hiz", !m[1] | as, lo_bus_hiz);
      chk("features", 7'((m[2] & sm) ? ~fd[6:0] & (m[0] ? 7'h67 : 7'h7e) : 7'h00), feature_en);
      chk("trs bits", {!m[5], m[3], g & (d[3:0] < 4'h4), g & (d[9:6] == 4'h0), g & d[10]},
          {flywheel_ext_lock, scramble_enable, trs_h, trs_v, trs_f});
      chk("line driver", m[6], serial_line_oe);
      chk("jtag pins", {m[7] & m[8], m[7], fd[7]}, {jtag_tck, jtag_tms, line_flag_timing_sel});
      apb(0, VIMC_REG_STATUS, 0);
      chk("status", {as, sm, 4'h0, 2'b11, m[7:0]}, rd[15:0] & 16'hc3ff);
    end
    settle(9'h042);
    chk("upper word", 10'(din_hi - 10'd3), word_hi);
    chk("lower word", 10'(din_hi - 10'd3) ^ 10'h2aa, word_lo);
    @(posedge sys_clk);
    blank_n_in <= 0;
    settle(9'h04a);
    chk("blanked words", {VIMC_LUMA_BLANK_RST, VIMC_CHROMA_BLANK_RST}, {word_hi, word_lo});
    @(posedge sys_clk);
    {blank_n_in, reset_n_shared} <= 2'b10;
    settle(9'h080);
    chk("jtag reset", 0, jtag_trst_n);
    settle(9'h042);
    chk("pins float", 2'b10, {din_pins_hiz, serial_line_oe});
    @(posedge sys_clk);
    reset_n_shared <= 1;
    apb(0, VIMC_REG_FEATURE_DIS, 0);
    chk("defaults", 0, rd);
    // host port: write feature_disable_reg, read it back serially, then over apb
    settle(9'h100);
    fd = 8'($urandom);
    @(posedge sys_clk);
    select_or_mode_pin <= 0;
    host_word(16'h0000);
    host_word({8'h00, fd});
    host_word(16'h8000);
    host_word(16'h0000);
    @(negedge sys_clk);
    chk("host read", {8'h00, fd}, hr);
    chk("host oe", 1, serial_out_pin_oe);
    @(posedge sys_clk);
    select_or_mode_pin <= 1;
    apb(0, VIMC_REG_FEATURE_DIS, 0);
    chk("host write", {24'h0, fd}, rd);
    end_of_test();
  end
endmodule // test_video_input_mode_control
